// ==== logic/sew_regs.svh ====
`ifndef SEW_REGS_SVH
`define SEW_REGS_SVH

// array geometry: nine address bits, sixteen-byte pages
`define SEW_ADDR_BITS 9
`define SEW_PAGE_BITS 4
`define SEW_DATA_BITS 8

// timing
`define SEW_CLK_PERIOD_NS 25
`define SEW_PROG_TIME_NS 5000000
`define SEW_PROG_CYCLES ((`SEW_PROG_TIME_NS + `SEW_CLK_PERIOD_NS - 1) / `SEW_CLK_PERIOD_NS)

// instruction byte fields
`define SEW_OP_GROUP 4'h0
`define SEW_OP_WRITE 3'h2
`define SEW_OP_WREN 3'h6
`define SEW_OP_WRDI 3'h4
`define SEW_TOP_ADDR_POS 3

// power-up and delivery values
`define SEW_ERASED_BYTE 8'hFF
`define SEW_BP_DELIVERED 2'h0
// select resets to asserted so a select already low at release is no falling edge
`define SEW_PIN_RESET 3'h6

`endif

// ==== logic/sew_pkg.sv ====
package sew_pkg;

  // which byte of the frame the serial receiver is filling
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_ADDR,
    PH_DATA
  } sew_phase_t;

  // core sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE
  } sew_state_t;

endpackage : sew_pkg

// ==== logic/sew_link.sv ====
`timescale 1ns/100ps
`include "sew_regs.svh"

module sew_link
#(
  parameter int PAGE_W = `SEW_PAGE_BITS
)
(
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_hold_n,
  input wire logic link_clr,
  output sew_pkg::sew_phase_t phase_ff,
  output logic [2:0] bit_ff,
  output logic [7:0] instr_ff,
  output logic [8:0] addr_ff,
  output logic [(8 << PAGE_W)-1:0] page_flat,
  output logic [(1 << PAGE_W)-1:0] valid_ff,
  output logic seq_ff
);
  import sew_pkg::*;

  localparam int SLOTS = 1 << PAGE_W;

  logic fresh_ff;
  logic fresh_set;
  logic [6:0] shift_ff;
  logic [PAGE_W-1:0] slot_ff;
  logic [7:0] page_ff [SLOTS];
  logic [2:0] cur_bit;
  sew_phase_t cur_phase;
  logic [7:0] byte_in;
  logic byte_done;
  logic data_done;

  // ------------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------------
  // sck stands still between frames, so a new frame is recognised at its
  // first edge by a flag that chip select presets while high
  assign cur_bit = fresh_ff ? 3'h0 : bit_ff;
  assign cur_phase = fresh_ff ? PH_INSTR : phase_ff;
  assign byte_in = {shift_ff, spi_mosi};
  assign byte_done = spi_hold_n && (cur_bit == 3'h7);
  assign data_done = byte_done && (cur_phase == PH_DATA);

  // the core's reset presets it too, since select may not have moved since power-up
  assign fresh_set = spi_cs_n || link_clr;

  always_ff @(posedge spi_sck or posedge fresh_set)
    if (fresh_set)
      fresh_ff <= 1'b1;
    else if (spi_hold_n)
      fresh_ff <= 1'b0;

  // one toggle per clocked frame lets the core ignore a select pulse with no clocks
  always_ff @(posedge spi_sck or posedge link_clr)
    if (link_clr)
      seq_ff <= 1'b0;
    else if (spi_hold_n && fresh_ff)
      seq_ff <= ~seq_ff;

  // ------------------------------------------------------------------
  // bit shifter
  // ------------------------------------------------------------------
  always_ff @(posedge spi_sck)
    if (spi_hold_n)
    begin
      shift_ff <= byte_in[6:0];
      bit_ff <= cur_bit + 3'h1;
    end

  always_ff @(posedge spi_sck)
    if (byte_done && cur_phase == PH_INSTR)
      phase_ff <= PH_ADDR;
    else if (byte_done && cur_phase == PH_ADDR)
      phase_ff <= PH_DATA;
    else if (spi_hold_n)
      phase_ff <= cur_phase;

  always_ff @(posedge spi_sck)
    if (byte_done && cur_phase == PH_INSTR)
      instr_ff <= byte_in;

  // ------------------------------------------------------------------
  // address and page gathering
  // ------------------------------------------------------------------
  always_ff @(posedge spi_sck)
    if (byte_done && cur_phase == PH_ADDR)
    begin
      addr_ff <= {instr_ff[`SEW_TOP_ADDR_POS], byte_in};
      slot_ff <= byte_in[PAGE_W-1:0];
    end
    else if (data_done)
      slot_ff <= slot_ff + PAGE_W'(1);

  always_ff @(posedge spi_sck)
    if (spi_hold_n && fresh_ff)
      valid_ff <= '0;
    else if (data_done)
      valid_ff[slot_ff] <= 1'b1;

  // a later byte for the same slot simply replaces the earlier one
  for (genvar g = 0; g < SLOTS; g++)
  begin : g_slot
    always_ff @(posedge spi_sck)
      if (data_done && slot_ff == PAGE_W'(g))
        page_ff[g] <= byte_in;
    assign page_flat[g*8 +: 8] = page_ff[g];
  end

endmodule : sew_link

// ==== logic/sew_eeprom.sv ====
`timescale 1ns/100ps
`include "sew_regs.svh"

module sew_eeprom
#(
  parameter int ADDR_W = `SEW_ADDR_BITS,
  parameter int PAGE_W = `SEW_PAGE_BITS,
  parameter int PROG_CYCLES = `SEW_PROG_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_hold_n,
  input wire logic wp_n,
  input wire logic page_protected,
  input wire logic bp_load,
  input wire logic [1:0] bp_value,
  input wire logic delivery_init,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic write_enable_latch,
  output logic program_busy_flag,
  output logic block_protect_hi,
  output logic block_protect_lo,
  output logic standby,
  output logic hold_active,
  output logic [ADDR_W-PAGE_W-1:0] target_page,
  output logic write_accepted,
  output logic write_rejected,
  output logic [7:0] rd_data
);
  import sew_pkg::*;

  localparam int SLOTS = 1 << PAGE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CNT_MAX = (PROG_CYCLES > DEPTH) ? PROG_CYCLES : DEPTH;
  localparam int CNT_W = $clog2(CNT_MAX + 1);
  localparam int PG_W = ADDR_W - PAGE_W;
  localparam logic [2:0] PIN_RST = `SEW_PIN_RESET;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // the instruction byte carries only one spare address bit, so nine is the top
  if (ADDR_W > 9 || ADDR_W <= PAGE_W)
  begin : g_bad_addr
    $error("address width must exceed page width and stay at or below nine");
  end

  // the page snapshot is written during the first cycles of the program count
  if (PROG_CYCLES < SLOTS)
  begin : g_bad_prog
    $error("program cycle count must cover at least one page of writes");
  end

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  // a pin level changes only once the second and third stages agree
  function automatic logic settle(input logic s2, input logic s3, input logic prev);
    settle = (s2 == s3) ? s3 : prev;
  endfunction : settle

  function automatic logic is_op(input logic [7:0] instr, input logic [2:0] code);
    is_op = (instr[7:4] == `SEW_OP_GROUP) && (instr[2:0] == code);
  endfunction : is_op

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [2:0] pins, lvl_ff, nxt_lvl;
  logic [2:0] sync_ff [3];
  logic cs_rise, cs_fall, wp_lvl, armed_ff, busy_start_ff, link_clr_ff, last_seq_ff;
  logic frame_ok, short_frame, is_write, write_ok, prog_write;
  logic wel_ff, busy_ff, standby_ff, hold_ff, accepted_ff, rejected_ff;
  logic [1:0] bp_ff;
  logic [PG_W-1:0] target_page_ff, prog_page_ff;
  logic [7:0] rd_data_ff;
  sew_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [7:0] snap_ff [SLOTS];
  logic [SLOTS-1:0] snap_valid_ff;
  logic [PAGE_W-1:0] prog_slot;
  logic [7:0] mem [DEPTH];

  sew_phase_t link_phase;
  logic [2:0] link_bit;
  logic [7:0] link_instr;
  logic [8:0] link_addr;
  logic [(8 << PAGE_W)-1:0] link_page;
  logic [SLOTS-1:0] link_valid;
  logic link_seq;

  // ------------------------------------------------------------------
  // serial receiver on the link clock
  // ------------------------------------------------------------------
  // its outputs are only read once select reads high at its second synchroniser stage; by then
  // the link clock has stopped and every one of them stands still
  sew_link #(
    .PAGE_W(PAGE_W)
  ) u_link (
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_hold_n(spi_hold_n),
    .link_clr(link_clr_ff),
    .phase_ff(link_phase),
    .bit_ff(link_bit),
    .instr_ff(link_instr),
    .addr_ff(link_addr),
    .page_flat(link_page),
    .valid_ff(link_valid),
    .seq_ff(link_seq)
  );

  always_ff @(posedge clk)
    if (!rst_n)
      link_clr_ff <= 1'b1;
    else
      link_clr_ff <= 1'b0;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  assign pins = {spi_hold_n, wp_n, spi_cs_n};

  for (genvar p = 0; p < 3; p++)
  begin : g_sync
    always_ff @(posedge clk)
      if (!rst_n)
        sync_ff[p] <= {3{PIN_RST[p]}};
      else
        sync_ff[p] <= {sync_ff[p][1:0], pins[p]};
    assign nxt_lvl[p] = settle(sync_ff[p][1], sync_ff[p][2], lvl_ff[p]);
  end

  // select reads as asserted at power-up: a select already low gives no fall,
  // so only a real falling edge arms the device
  always_ff @(posedge clk)
    if (!rst_n)
      lvl_ff <= PIN_RST;
    else
      lvl_ff <= nxt_lvl;

  assign cs_rise = !lvl_ff[0] && nxt_lvl[0];
  assign cs_fall = lvl_ff[0] && !nxt_lvl[0];
  assign wp_lvl = lvl_ff[1];

  // ------------------------------------------------------------------
  // frame bookkeeping
  // ------------------------------------------------------------------
  // a frame already under way at power-up is never honoured
  always_ff @(posedge clk)
    if (!rst_n)
      armed_ff <= 1'b0;
    else if (cs_fall)
      armed_ff <= 1'b1;

  always_ff @(posedge clk)
    if (!rst_n)
      busy_start_ff <= 1'b0;
    else if (cs_fall)
      busy_start_ff <= busy_ff;

  always_ff @(posedge clk)
    if (!rst_n)
      last_seq_ff <= 1'b0;
    else if (cs_rise)
      last_seq_ff <= link_seq;

  assign frame_ok = cs_rise && armed_ff && (link_seq != last_seq_ff);
  assign short_frame = (link_phase == PH_DATA) && (link_bit == 3'h0) && (link_valid == '0);

  // ------------------------------------------------------------------
  // write acceptance
  // ------------------------------------------------------------------
  assign is_write = is_op(link_instr, `SEW_OP_WRITE);

  // one data byte already qualifies, which is the single-byte write
  always_comb
  begin
    write_ok = frame_ok && is_write;
    write_ok = write_ok && (link_phase == PH_DATA) && (link_valid != '0);
    write_ok = write_ok && (link_bit == 3'h0);
    write_ok = write_ok && wel_ff;
    write_ok = write_ok && !busy_start_ff && !busy_ff;
    write_ok = write_ok && wp_lvl;
    write_ok = write_ok && !page_protected;
  end

  always_ff @(posedge clk)
    if (!rst_n)
    begin
      accepted_ff <= 1'b0;
      rejected_ff <= 1'b0;
    end
    else
    begin
      accepted_ff <= write_ok;
      rejected_ff <= frame_ok && is_write && !write_ok && !short_frame;
    end

  // the protection input answers for the page the receiver holds; the address
  // is copied only while the second select stage reads high and sck stands still
  always_ff @(posedge clk)
    if (!rst_n)
      target_page_ff <= '0;
    else if (sync_ff[0][1])
      target_page_ff <= link_addr[ADDR_W-1:PAGE_W];

  // ------------------------------------------------------------------
  // write enable latch
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
    if (!rst_n)
      wel_ff <= 1'b0;
    else if (!wp_lvl)
      wel_ff <= 1'b0;
    else if (write_ok)
      wel_ff <= 1'b0;
    else if (frame_ok && link_phase == PH_ADDR && link_bit == 3'h0)
    begin
      if (is_op(link_instr, `SEW_OP_WRDI))
        wel_ff <= 1'b0;
      else if (is_op(link_instr, `SEW_OP_WREN))
        wel_ff <= 1'b1;
    end

  // ------------------------------------------------------------------
  // page snapshot
  // ------------------------------------------------------------------
  // copied out at acceptance so that polling frames during the program
  // cycle cannot disturb the bytes still waiting to be stored
  for (genvar s = 0; s < SLOTS; s++)
  begin : g_snap
    always_ff @(posedge clk)
      if (write_ok)
        snap_ff[s] <= link_page[s*8 +: 8];
  end

  always_ff @(posedge clk)
    if (!rst_n)
      snap_valid_ff <= '0;
    else if (write_ok)
      snap_valid_ff <= link_valid;

  always_ff @(posedge clk)
    if (!rst_n)
      prog_page_ff <= '0;
    else if (write_ok)
      prog_page_ff <= link_addr[ADDR_W-1:PAGE_W];

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + CNT_W'(1);
    case (state_ff)
      ST_IDLE:
      begin
        nxt_cnt = '0;
        if (write_ok)
          nxt_state = ST_PROG;
        else if (delivery_init && lvl_ff[0])
          nxt_state = ST_ERASE;
      end
      ST_PROG:
      begin
        if (cnt_ff == CNT_W'(PROG_CYCLES - 1))
          nxt_state = ST_IDLE;
      end
      ST_ERASE:
      begin
        if (cnt_ff == CNT_W'(DEPTH - 1))
          nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;

  always_ff @(posedge clk)
    if (!rst_n)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;

  // flag mirrors the next state so it changes in the same edge as the sequencer
  always_ff @(posedge clk)
    if (!rst_n)
      busy_ff <= 1'b0;
    else
      busy_ff <= (nxt_state != ST_IDLE);

  // ------------------------------------------------------------------
  // array
  // ------------------------------------------------------------------
  // no reset: the contents are non-volatile and only the delivery sweep and program cycles write them
  assign prog_slot = cnt_ff[PAGE_W-1:0];
  assign prog_write = (state_ff == ST_PROG) && (cnt_ff < CNT_W'(SLOTS)) &&
    snap_valid_ff[prog_slot];

  always_ff @(posedge clk)
    if (prog_write)
      mem[{prog_page_ff, prog_slot}] <= snap_ff[prog_slot];
    else if (state_ff == ST_ERASE)
      mem[cnt_ff[ADDR_W-1:0]] <= `SEW_ERASED_BYTE;

  always_ff @(posedge clk)
    if (!rst_n)
      rd_data_ff <= '0;
    else
      rd_data_ff <= mem[rd_addr];

  // ------------------------------------------------------------------
  // block-protect bits
  // ------------------------------------------------------------------
  // deliberately outside the reset so they survive power cycles; they read
  // unknown until the first delivery sweep or load. frozen while busy.
  always_ff @(posedge clk)
    if (state_ff == ST_IDLE && nxt_state == ST_ERASE)
      bp_ff <= `SEW_BP_DELIVERED;
    else if (bp_load && state_ff == ST_IDLE && !write_ok)
      bp_ff <= bp_value;

  // ------------------------------------------------------------------
  // power state
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
    if (!rst_n)
      standby_ff <= 1'b1;
    else
      standby_ff <= (nxt_lvl[0] || !(armed_ff || cs_fall)) && (nxt_state == ST_IDLE);

  // pause only counts while selected, and is cleared by power-up
  always_ff @(posedge clk)
    if (!rst_n)
      hold_ff <= 1'b0;
    else
      hold_ff <= !nxt_lvl[2] && !nxt_lvl[0] && (armed_ff || cs_fall);

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign write_enable_latch = wel_ff;
  assign program_busy_flag = busy_ff;
  assign block_protect_hi = bp_ff[1];
  assign block_protect_lo = bp_ff[0];
  assign standby = standby_ff;
  assign hold_active = hold_ff;
  assign target_page = target_page_ff;
  assign write_accepted = accepted_ff;
  assign write_rejected = rejected_ff;
  assign rd_data = rd_data_ff;

endmodule : sew_eeprom

// ==== verification/sew_eeprom_props.sv ====
`timescale 1ns/100ps
module sew_eeprom_props
#(
  parameter int PROG_CYCLES = 32
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wp_n,
  input wire logic page_protected,
  input wire logic write_enable_latch,
  input wire logic program_busy_flag,
  input wire logic standby,
  input wire logic hold_active,
  input wire logic write_accepted,
  input wire logic write_rejected
);
  // ----------------------------------------
  // cycle length bookkeeping
  // ----------------------------------------
  logic [31:0] busy_cnt_ff;
  logic from_write_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n || !program_busy_flag)
      busy_cnt_ff <= 32'h0;
    else
      busy_cnt_ff <= busy_cnt_ff + 32'h1;
  end

  // the delivery sweep also raises busy, so only program cycles are timed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      from_write_ff <= 1'b0;
    else if (write_accepted)
      from_write_ff <= 1'b1;
    else if (!program_busy_flag)
      from_write_ff <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    write_accepted ##0 program_busy_flag;
  endsequence
  sequence s_wp_held;
    (!wp_n) [*6];
  endsequence

  AST_PWRUP_STATE: assert property ($rose(rst_n) |-> !write_enable_latch
    && !program_busy_flag && standby && !hold_active) else $error("bad state after reset");
  AST_ACCEPT_STARTS: assert property (write_accepted |-> s_accept ##0 !write_enable_latch
    ##0 !standby) else $error("accepted write did not start a cycle");
  AST_ACCEPT_NEEDS_WEL: assert property (write_accepted |-> $past(write_enable_latch))
    else $error("write accepted without enable latch");
  AST_ACCEPT_NOT_BUSY: assert property (write_accepted |-> !$past(program_busy_flag))
    else $error("write accepted while busy");
  AST_WP_CLEARS_WEL: assert property (s_wp_held |-> !write_enable_latch)
    else $error("enable latch set while write protect low");
  AST_WP_BLOCKS: assert property (s_wp_held |-> !write_accepted)
    else $error("write accepted while write protect low");
  AST_PROTECT_BLOCKS: assert property (page_protected [*8] |-> !write_accepted)
    else $error("write accepted on protected page");
  AST_ACCEPT_ONE_CYCLE: assert property (write_accepted |=> !write_accepted
    && program_busy_flag) else $error("accept pulse too long");
  AST_REJECT_NO_CYCLE: assert property (write_rejected && !program_busy_flag
    |=> !program_busy_flag) else $error("refused write started a cycle");
  AST_CYCLE_LENGTH: assert property ($fell(program_busy_flag) && from_write_ff
    |-> busy_cnt_ff == PROG_CYCLES) else $error("program cycle length wrong");
endmodule : sew_eeprom_props

// ==== verification/sew_host_model.sv ====
`timescale 1ns/100ps
module sew_host_model
(
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // ----------------------------------------
  // frame bytes and shifting
  // ----------------------------------------
  logic [7:0] fr [0:19];

  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  // nb whole bytes then nx stray bits, msb first; clock still outside frames
  task automatic send(input int nb, input int nx);
    int i;
    spi_cs_n = 1'b0;
    #7;
    for (i = 0; i < nb * 8 + nx; i++)
    begin
      spi_mosi = fr[i / 8][7 - i % 8];
      #3 spi_sck = 1'b1;
      #3 spi_sck = 1'b0;
    end
    #1 spi_cs_n = 1'b1;
    // a released line must not look like a held bit
    spi_mosi = ~spi_mosi;
  endtask : send

  // holds select at a level with the clock still, for pause and power-up cases
  task automatic set_select(input logic level);
    spi_cs_n = level;
  endtask : set_select
endmodule : sew_host_model

// ==== verification/test_sew_eeprom.sv ====
`timescale 1ns/100ps
module test_sew_eeprom;
  localparam int PROG = 32;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic hold_n = 1'b1;
  logic page_protected = 1'b0;
  logic bp_load = 1'b0;
  logic [1:0] bp_value = 2'h0;
  logic delivery_init = 1'b0;
  logic [8:0] rd_addr = 9'h000;
  logic spi_sck, spi_cs_n, spi_mosi, write_enable_latch, program_busy_flag;
  logic block_protect_hi, block_protect_lo, standby, hold_active;
  logic write_accepted, write_rejected, acc, rej;
  logic [4:0] target_page;
  logic [7:0] rd_data;
  int errors = 0;
  int total_checks = 0;
  wire logic [3:0] st = {write_enable_latch, program_busy_flag, standby, hold_active};
  wire logic [1:0] bp = {block_protect_hi, block_protect_lo};

  always #12.5 clk = ~clk;

  sew_host_model i_sew_host_model (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  sew_eeprom #(.PROG_CYCLES(PROG)) i_sew_eeprom (.clk(clk), .rst_n(rst_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_hold_n(hold_n), .wp_n(wp_n),
    .page_protected(page_protected), .bp_load(bp_load), .bp_value(bp_value),
    .delivery_init(delivery_init), .rd_addr(rd_addr), .write_enable_latch(write_enable_latch),
    .program_busy_flag(program_busy_flag), .block_protect_hi(block_protect_hi),
    .block_protect_lo(block_protect_lo), .standby(standby), .hold_active(hold_active),
    .target_page(target_page), .write_accepted(write_accepted),
    .write_rejected(write_rejected), .rd_data(rd_data));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic frame(input int nb, input int nx);
    @(negedge clk);
    i_sew_host_model.send(nb, nx);
    acc = 1'b0;
    rej = 1'b0;
    // pulses come 3..4 clocks after select rises; this also keeps the frame gap
    repeat (12)
    begin
      @(negedge clk);
      acc = acc | write_accepted;
      rej = rej | write_rejected;
    end
  endtask : frame

  task automatic op(input logic [7:0] code);
    i_sew_host_model.fr[0] = code;
    frame(1, 0);
  endtask : op

  task automatic wr(input logic [8:0] a, input int nb, input int nx, input logic [7:0] exp);
    i_sew_host_model.fr[0] = {4'h0, a[8], 3'h2};
    i_sew_host_model.fr[1] = a[7:0];
    frame(nb + 2, nx);
    check({6'h00, acc, rej}, exp);
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_addr = a;
    repeat (2) @(negedge clk);
    check(rd_data, exp);
  endtask : rd

  task automatic wait_idle();
    int i;
    for (i = 0; i < PROG + 600 && program_busy_flag; i++)
      @(negedge clk);
    check(8'(program_busy_flag), 8'h00);
  endtask : wait_idle

  task automatic power_cycle();
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : power_cycle

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_powerup();
    check(8'(st), 8'h02);
    delivery_init = 1'b1;
    @(negedge clk);
    delivery_init = 1'b0;
    @(negedge clk);
    check(8'(st), 8'h04);
    wait_idle();
    check(8'(bp), 8'h00);
    rd(9'h000, 8'hFF);
    rd(9'h1FF, 8'hFF);
  endtask : t_powerup

  task automatic t_bp_keep();
    bp_value = 2'h3;
    bp_load = 1'b1;
    @(negedge clk);
    bp_load = 1'b0;
    @(negedge clk);
    power_cycle();
    check(8'(bp), 8'h03);
    check(8'(st), 8'h02);
    bp_value = 2'h0;
    bp_load = 1'b1;
    @(negedge clk);
    bp_load = 1'b0;
  endtask : t_bp_keep

  task automatic t_hold();
    hold_n = 1'b0;
    i_sew_host_model.set_select(1'b0);
    repeat (6) @(negedge clk);
    check(8'(st), 8'h01);
    power_cycle();
    check(8'(st), 8'h02);
    i_sew_host_model.set_select(1'b1);
    hold_n = 1'b1;
    repeat (8) @(negedge clk);
    check(8'(st), 8'h02);
  endtask : t_hold

  task automatic t_single();
    i_sew_host_model.fr[2] = 8'h55;
    wr(9'h020, 1, 0, 8'h01);
    op(8'h06);
    check(8'(st), 8'h0A);
    i_sew_host_model.fr[2] = 8'h3C;
    wr(9'h1A5, 1, 0, 8'h02);
    check(8'(target_page), 8'h1A);
    check(8'(st), 8'h04);
    wait_idle();
    check(8'(st), 8'h02);
    rd(9'h1A5, 8'h3C);
    rd(9'h1A4, 8'hFF);
    rd(9'h020, 8'hFF);
  endtask : t_single

  task automatic t_page();
    int k;
    int s;
    op(8'h0E);
    for (k = 0; k < 18; k++)
      i_sew_host_model.fr[2 + k] = 8'h40 + 8'(k);
    wr(9'h00E, 18, 0, 8'h02);
    wait_idle();
    for (s = 0; s < 16; s++)
    begin
      k = (s + 2) % 16;
      if (k < 2)
        k = k + 16;
      rd(9'(s), 8'h40 + 8'(k));
    end
    rd(9'h010, 8'hFF);
  endtask : t_page

  task automatic t_refusals();
    op(8'h06);
    i_sew_host_model.fr[2] = 8'hAA;
    wr(9'h030, 1, 0, 8'h02);
    op(8'h06);
    wr(9'h031, 1, 0, 8'h01);
    wait_idle();
    wr(9'h040, 2, 3, 8'h01);
    op(8'h04);
    check(8'(st), 8'h02);
    op(8'h06);
    wp_n = 1'b0;
    repeat (6) @(negedge clk);
    check(8'(st), 8'h02);
    wr(9'h050, 1, 0, 8'h01);
    wp_n = 1'b1;
    op(8'h06);
    page_protected = 1'b1;
    wr(9'h060, 1, 0, 8'h01);
    check(8'(target_page), 8'h06);
    page_protected = 1'b0;
    rd(9'h031, 8'hFF);
    rd(9'h040, 8'hFF);
    rd(9'h050, 8'hFF);
    rd(9'h060, 8'hFF);
  endtask : t_refusals

  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_powerup();
    t_bp_keep();
    t_hold();
    t_single();
    t_page();
    t_refusals();
    give_verdict();
  end

  // the whole run needs about a thousand clocks; this allows many times that
  initial
  begin
    #500000;
    errors++;
    give_verdict();
  end
endmodule : test_sew_eeprom

bind sew_eeprom sew_eeprom_props #(.PROG_CYCLES(PROG_CYCLES)) i_sew_eeprom_props (.clk(clk),
  .rst_n(rst_n), .wp_n(wp_n), .page_protected(page_protected),
  .write_enable_latch(write_enable_latch), .program_busy_flag(program_busy_flag),
  .standby(standby), .hold_active(hold_active), .write_accepted(write_accepted),
  .write_rejected(write_rejected));
